// ===== dv/flash_sense_regs_assertions.sv
// Concurrent checks on the sense and low-battery register bank
`timescale 1ns/1ps
`default_nettype none
module flash_sense_regs_assertions (
    // Clock, reset and register port
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [7:0]  reg_rdata,
    // Sense and power stage
    input wire logic        peak_limit_hit,
    input wire logic        sense_led_vf_en,
    input wire logic        sense_die_temp_en,
    input wire logic        sense_external_en,
    input wire logic        sample_strobe,
    input wire logic        soft_limit_active,
    input wire logic        peak_shutdown,
    input wire logic [10:0] led_current_ma
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic [7:0] wd;                            // Write data of last edge
    wire w8 = reg_write && reg_addr == 8'h08;  // Converter write
    wire w9 = reg_write && reg_addr == 8'h09;  // Low-battery write
    // Keep the data of the last edge for the checks
    always_ff @(posedge clk) wd <= reg_wdata;
    sel_led_a: assert property (w8 |=> sense_led_vf_en == (wd[1:0] == 2'h1))
        else $error("led select");
    sel_temp_a: assert property (w8 |=> sense_die_temp_en == (wd[1:0] == 2'h2))
        else $error("temp select");
    sel_ext_a: assert property (w8 |=> sense_external_en == (wd[1:0] == 2'h3))
        else $error("ext select");
    soft_write_a: assert property (w9 |=> soft_limit_active == wd[7]) else $error("soft bit");
    // A limit hit sets the latch even when a clearing write meets it
    shut_set_a: assert property (!soft_limit_active && peak_limit_hit |=> peak_shutdown)
        else $error("no shutdown");
    shut_zero_a: assert property (peak_shutdown ##1 peak_shutdown |-> led_current_ma == 11'h000)
        else $error("current in shutdown");
    strobe_pulse_a: assert property (sample_strobe |=> !sample_strobe) else $error("strobe too long");
    soft_read_a: assert property (reg_read && reg_addr == 8'h09 |=> reg_rdata[7] == $past(soft_limit_active))
        else $error("soft readback");
    reset_vals_a: assert property ($fell(reset) |-> soft_limit_active && !sense_led_vf_en)
        else $error("reset values");
    // Main scenarios
    cover property (sample_strobe);
    cover property (peak_shutdown);
    cover property (w9 ##1 !soft_limit_active);
endmodule // flash_sense_regs_assertions
bind flash_sense_regs flash_sense_regs_assertions chk_i (.clk, .reset, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .peak_limit_hit, .sense_led_vf_en, .sense_die_temp_en, .sense_external_en,
    .sample_strobe, .soft_limit_active, .peak_shutdown, .led_current_ma);
`default_nettype wire

// ===== dv/flash_sense_regs_bench.sv
// Self-checking bench for the sense and low-battery register bank
`timescale 1ns/1ps
`default_nettype none
module flash_sense_regs_bench;
    logic clk = 1'b0;                   // 200 MHz clock
    logic reset = 1'b1;                 // Synchronous reset
    logic [7:0] reg_addr = 8'h00;       // Register port
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_rdata;
    logic [3:0] code;                   // From front-end model
    logic [11:0] supply_mv = 12'hfff;   // Supply level
    logic peak_hit = 1'b0;
    logic [10:0] req_ma = 11'h5dc;      // 1500 mA asked
    logic led_en, temp_en, ext_en, shut;
    logic tm;                           // Test mode output
    logic [10:0] led_ma;
    logic [11:0] thr;                   // Expected threshold in mV
    logic [7:0] rv;                     // Last read value
    logic [3:0] res[4] = '{4'h0, 4'h5, 4'h9, 4'hc};  // Expected results
    int err_total = 0;
    int tests_run = 0;
    // Clock
    always #2.5 clk = ~clk;
    flash_sense_regs #(.CONV_WAIT(8'h02)) DUT (.clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata, .analog_code(code), .supply_mv, .peak_limit_hit(peak_hit), .requested_led_ma(req_ma),
        .sense_led_vf_en(led_en), .sense_die_temp_en(temp_en), .sense_external_en(ext_en), .sample_strobe(),
        .test_mode(tm), .soft_limit_active(), .peak_shutdown(shut), .led_current_ma(led_ma));
    sense_front_model front (.led_en, .temp_en, .ext_en, .code);
    // Compare and count
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Register write, held for one taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    // Register read and compare
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        @(posedge clk);
        #1 rv = reg_rdata;
        chk(rv, exp);
    endtask
    // Verdict
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        complete_run();
    end
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        rdc(8'h08, 8'h00);
        rdc(8'h09, 8'hd0);
        rdc(8'h0a, 8'h00);
        // Test bit and writable result field while the converter is off
        wr(8'h08, 8'ha8);
        #1 chk({11'h000, tm}, 12'h001);
        rdc(8'h08, 8'ha8);
        // Every source select, then its result
        for (int s = 0; s < 4; s++) begin
            wr(8'h08, 8'(s));
            #1 chk({9'h000, ext_en, temp_en, led_en}, 12'((1 << s) >> 1));
            repeat (8) @(posedge clk);
            rdc(8'h08, {2'h0, res[s], 2'(s)});
        end
        wr(8'h09, 8'hfb);
        rdc(8'h09, 8'hd3);
        // Threshold edges: at level no flag, one below sets it
        for (int c = 1; c < 8; c += 3) begin
            thr = 12'hce4 + 12'h032 * 12'(c - 1);
            wr(8'h09, 8'h80 | 8'(c));
            supply_mv <= thr;
            rdc(8'h08, 8'h33);
            chk(led_ma, 12'h5dc);
            supply_mv <= thr - 12'h001;
            rdc(8'h08, 8'h73);
            chk(led_ma, 12'h320);
        end
        wr(8'h09, 8'h80);
        rdc(8'h08, 8'h33);
        // Peak limit with soft limit on, then off
        peak_hit <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk(shut, 12'h000);
        wr(8'h09, 8'h00);
        repeat (3) @(posedge clk);
        #1 chk(shut, 12'h001);
        chk(led_ma, 12'h000);
        // A clearing write that meets a live limit hit loses to the set
        wr(8'h09, 8'h80);
        #1 chk(shut, 12'h001);
        peak_hit <= 1'b0;
        wr(8'h09, 8'h80);
        #1 chk(shut, 12'h000);
        // Reset in mid-run brings back the reset values
        reset <= 1'b1;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        rdc(8'h08, 8'h00);
        rdc(8'h09, 8'hd0);
        complete_run();
    end
endmodule // flash_sense_regs_bench
`default_nettype wire

// ===== dv/sense_front_model.sv
// Behavioural analog front end that feeds raw converter codes
`timescale 1ns/1ps
`default_nettype none
module sense_front_model (
    // Source selects
    input wire logic  led_en,
    input wire logic  temp_en,
    input wire logic  ext_en,
    // Raw code
    output logic [3:0] code
);
    // A distinct code per source, so a wrong source pick shows up
    assign code = led_en ? 4'h5 : temp_en ? 4'h9 : ext_en ? 4'hc : 4'h3;
endmodule // sense_front_model
`default_nettype wire

// ===== verilog/conversion_sequencer.sv
// Sequencer that starts conversions and captures the 4-bit converter result
`timescale 1ns/1ps
`default_nettype none
`include "flash_sense_defines.svh"
module conversion_sequencer #(
    parameter int           RESULT_WIDTH = 4,
    parameter logic [7:0]   WAIT_CYCLES  = `CONV_WAIT_CYCLES
) (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       reset,
    // Control
    input  wire logic                       enable,
    // Analog converter side
    input  wire logic [RESULT_WIDTH-1:0]    analog_code,
    output logic                            sample_strobe,
    // Result
    output logic [RESULT_WIDTH-1:0]         result,
    output logic                            result_valid
);
    flash_sense_pkg::conv_state_t   state;       // Current state
    flash_sense_pkg::conv_state_t   next_state;  // Following state
    logic [7:0]                     wait_count;  // Settling counter

    wire wait_done = (wait_count == WAIT_CYCLES - 8'h01);

    // Next state decode
    always_comb begin
        next_state = state;
        case (state)
            flash_sense_pkg::conv_idle:  next_state = enable ? flash_sense_pkg::conv_wait
                                                             : flash_sense_pkg::conv_idle;
            flash_sense_pkg::conv_wait:  next_state = !enable ? flash_sense_pkg::conv_idle
                                                   : (wait_done ? flash_sense_pkg::conv_store
                                                                : flash_sense_pkg::conv_wait);
            flash_sense_pkg::conv_store: next_state = enable ? flash_sense_pkg::conv_wait
                                                             : flash_sense_pkg::conv_idle;
            default:                     next_state = flash_sense_pkg::conv_idle;
        endcase
    end

    assign sample_strobe = (state == flash_sense_pkg::conv_store);

    // State, counter and captured result
    always_ff @(posedge clk) begin
        if (reset) begin
            state        <= flash_sense_pkg::conv_idle;
            wait_count   <= 8'h00;
            result       <= `CONV_RESULT_RESET;
            result_valid <= 1'b0;
        end else begin
            state        <= next_state;
            wait_count   <= (state == flash_sense_pkg::conv_wait) ? wait_count + 8'h01 : 8'h00;
            result_valid <= sample_strobe;
            if (sample_strobe) begin
                result <= analog_code;  // Latest result kept until next conversion
            end
        end
    end
endmodule // conversion_sequencer
`default_nettype wire

// ===== verilog/flash_sense_defines.svh
// Offsets, field positions, reset values and codes of the sense and low-battery registers
`ifndef FLASH_SENSE_DEFINES_SVH
`define FLASH_SENSE_DEFINES_SVH
`define CONV_REG_ADDR        8'h08
`define LOWBAT_REG_ADDR      8'h09
`define CONV_TEST_BIT        7
`define CONV_FLAG_BIT        6
`define CONV_RESULT_HI       5
`define CONV_RESULT_LO       2
`define CONV_SEL_HI          1
`define CONV_SEL_LO          0
`define LOWBAT_SOFT_BIT      7
`define LOWBAT_CUR_HI        6
`define LOWBAT_CUR_LO        3
`define LOWBAT_THR_HI        2
`define LOWBAT_THR_LO        0
`define CONV_TEST_RESET      1'h0
`define CONV_SEL_RESET       2'h0
`define CONV_RESULT_RESET    4'h0
`define LOWBAT_SOFT_RESET    1'h1
`define LOWBAT_CUR_RESET     4'ha
`define LOWBAT_THR_OFF       3'h0
`define LOWBAT_CUR_BASE_MA   11'h12c
`define LOWBAT_CUR_STEP_MA   11'h032
`define LOWBAT_THR_BASE_MV   12'hce4
`define LOWBAT_THR_STEP_MV   12'h032
`define CONV_WAIT_CYCLES     8'h10
`define READ_NONE            8'h00
`endif

// ===== verilog/flash_sense_pkg.sv
// Types shared by the sense and low-battery register bank
`default_nettype none
package flash_sense_pkg;
    // Measurement source of the 4-bit converter
    typedef enum logic [1:0] {
        sense_off       = 2'b00,
        sense_led_vf    = 2'b01,
        sense_die_temp  = 2'b10,
        sense_external  = 2'b11
    } sense_select_t;
    // Converter sequencer states
    typedef enum logic [1:0] {
        conv_idle   = 2'b00,
        conv_wait   = 2'b01,
        conv_store  = 2'b10
    } conv_state_t;
endpackage
`default_nettype wire

// ===== verilog/flash_sense_regs.sv
// Converter control/status and low-battery mode registers of the flash driver
`timescale 1ns/1ps
`default_nettype none
`include "flash_sense_defines.svh"
module flash_sense_regs #(
    parameter logic [7:0] CONV_WAIT = `CONV_WAIT_CYCLES
) (
    // Clock and reset
    input  wire logic           clk,
    input  wire logic           reset,
    // Register port from the two-wire interface
    input  wire logic [7:0]     reg_addr,
    input  wire logic [7:0]     reg_wdata,
    input  wire logic           reg_write,
    input  wire logic           reg_read,
    output logic [7:0]          reg_rdata,
    // Analog sense side
    input  wire logic [3:0]     analog_code,
    input  wire logic [11:0]    supply_mv,
    input  wire logic           peak_limit_hit,
    input  wire logic [10:0]    requested_led_ma,
    // Converter controls
    output logic                sense_led_vf_en,
    output logic                sense_die_temp_en,
    output logic                sense_external_en,
    output logic                sample_strobe,
    output logic                test_mode,
    // Power stage controls
    output logic                soft_limit_active,
    output logic                peak_shutdown,
    output logic [10:0]         led_current_ma
);
    // Stored register fields
    logic                       test_bit;                // Test mode bit
    flash_sense_pkg::sense_select_t sense_sel;           // Measurement source
    logic                       soft_peak_limit_enable;  // Soft limit select
    logic [3:0]                 low_supply_led_current;  // Low-battery current code
    logic [2:0]                 low_supply_threshold;    // Threshold code
    logic                       low_supply_flag;         // Registered status
    logic [3:0]                 conversion_result;       // Latest result
    logic                       shutdown_latch;          // Hard limit shutdown

    // Address decode
    wire conv_hit   = (reg_addr == `CONV_REG_ADDR);
    wire lowbat_hit = (reg_addr == `LOWBAT_REG_ADDR);
    wire conv_wr    = reg_write && conv_hit;
    wire lowbat_wr  = reg_write && lowbat_hit;

    // Threshold in mV from its code
    wire        lowbat_on    = (low_supply_threshold != `LOWBAT_THR_OFF);
    wire [11:0] threshold_mv = `LOWBAT_THR_BASE_MV
                             + 12'(`LOWBAT_THR_STEP_MV * 12'(low_supply_threshold - 3'h1));
    wire        supply_low   = lowbat_on && (supply_mv < threshold_mv);

    // Low-battery current in mA from its code
    wire [10:0] lowbat_ma = `LOWBAT_CUR_BASE_MA
                          + 11'(`LOWBAT_CUR_STEP_MA * 11'(low_supply_led_current));

    // Source decode
    wire conv_enable = (sense_sel != flash_sense_pkg::sense_off);
    assign sense_led_vf_en   = (sense_sel == flash_sense_pkg::sense_led_vf);
    assign sense_die_temp_en = (sense_sel == flash_sense_pkg::sense_die_temp);
    assign sense_external_en = (sense_sel == flash_sense_pkg::sense_external);
    assign test_mode         = test_bit;

    // Peak limit behaviour
    assign soft_limit_active = soft_peak_limit_enable;
    assign peak_shutdown     = shutdown_latch;

    // LED current clamp in low-battery mode
    wire [10:0] clamped_ma = (low_supply_flag && (requested_led_ma > lowbat_ma))
                           ? lowbat_ma : requested_led_ma;

    // Result capture from the converter sequencer
    wire [3:0] seq_result;
    wire       seq_valid;
    conversion_sequencer #(
        .RESULT_WIDTH (4),
        .WAIT_CYCLES  (CONV_WAIT)
    ) u_seq (
        .clk           (clk),
        .reset         (reset),
        .enable        (conv_enable),
        .analog_code   (analog_code),
        .sample_strobe (sample_strobe),
        .result        (seq_result),
        .result_valid  (seq_valid)
    );

    // Read data assembly
    wire [7:0] conv_read   = {test_bit, low_supply_flag, conversion_result, sense_sel};
    wire [7:0] lowbat_read = {soft_peak_limit_enable, low_supply_led_current, low_supply_threshold};
    wire [7:0] read_mux    = conv_hit ? conv_read : (lowbat_hit ? lowbat_read : `READ_NONE);

    // Converter register fields
    always_ff @(posedge clk) begin
        if (reset) begin
            test_bit  <= `CONV_TEST_RESET;
            sense_sel <= flash_sense_pkg::sense_off;
        end else if (conv_wr) begin
            test_bit  <= reg_wdata[`CONV_TEST_BIT];
            sense_sel <= flash_sense_pkg::sense_select_t'(reg_wdata[`CONV_SEL_HI:`CONV_SEL_LO]);
        end
    end

    // Result field, converter capture wins over host write
    always_ff @(posedge clk) begin
        if (reset) begin
            conversion_result <= `CONV_RESULT_RESET;
        end else if (seq_valid) begin
            conversion_result <= seq_result;
        end else if (conv_wr) begin
            conversion_result <= reg_wdata[`CONV_RESULT_HI:`CONV_RESULT_LO];
        end
    end

    // Low-battery register fields; current field is read-only
    always_ff @(posedge clk) begin
        if (reset) begin
            soft_peak_limit_enable <= `LOWBAT_SOFT_RESET;
            low_supply_led_current <= `LOWBAT_CUR_RESET;
            low_supply_threshold   <= `LOWBAT_THR_OFF;
        end else if (lowbat_wr) begin
            soft_peak_limit_enable <= reg_wdata[`LOWBAT_SOFT_BIT];
            low_supply_threshold   <= reg_wdata[`LOWBAT_THR_HI:`LOWBAT_THR_LO];
        end
    end

    // Status flag, shutdown latch, outputs
    always_ff @(posedge clk) begin
        if (reset) begin
            low_supply_flag <= 1'b0;
            shutdown_latch  <= 1'b0;
            led_current_ma  <= 11'h000;
            reg_rdata       <= `READ_NONE;
        end else begin
            low_supply_flag <= supply_low;
            if (peak_limit_hit && !soft_peak_limit_enable) begin
                shutdown_latch <= 1'b1;
            end else if (lowbat_wr && reg_wdata[`LOWBAT_SOFT_BIT]) begin
                shutdown_latch <= 1'b0;
            end
            led_current_ma  <= shutdown_latch ? 11'h000 : clamped_ma;
            if (reg_read) begin
                reg_rdata <= read_mux;
            end
        end
    end
endmodule // flash_sense_regs
`default_nettype wire
